// file: rtl/cdt_pkg.sv
`default_nettype none

package cdt_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_ROOT_SEL      = 10'h004;
  localparam logic [9:0] IDX_PLAY_N        = 10'h00b;
  localparam logic [9:0] IDX_PLAY_M        = 10'h00c;
  localparam logic [9:0] IDX_PLAY_OSR_HI   = 10'h00d;
  localparam logic [9:0] IDX_PLAY_OSR_LO   = 10'h00e;
  localparam logic [9:0] IDX_REC_N         = 10'h012;
  localparam logic [9:0] IDX_REC_M         = 10'h013;
  localparam logic [9:0] IDX_REC_OSR       = 10'h014;
  localparam logic [9:0] IDX_BYPASS        = 10'h018;
  localparam logic [9:0] IDX_CHAN_POWER    = 10'h019;
  localparam logic [9:0] IDX_REC_STATUS    = 10'h024;
  localparam logic [9:0] IDX_PLAY_STATUS   = 10'h025;
  localparam logic [9:0] IDX_P1_SRC        = 10'h08b;
  localparam logic [9:0] IDX_P1_DIV        = 10'h08c;
  localparam logic [9:0] IDX_P1_OUTSEL     = 10'h08e;
  localparam logic [9:0] IDX_P2_SRC        = 10'h09b;
  localparam logic [9:0] IDX_P2_DIV        = 10'h09c;
  localparam logic [9:0] IDX_P2_OUTSEL     = 10'h09e;
  localparam logic [9:0] IDX_P3_SRC        = 10'h0ab;
  localparam logic [9:0] IDX_P3_DIV        = 10'h0ac;
  localparam logic [9:0] IDX_P3_OUTSEL     = 10'h0ae;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PLAY_ROOT_LSB   = 4;
  localparam int REC_ROOT_LSB    = 0;
  localparam int POWER_BIT       = 7;
  localparam int BYP_CORE_BIT    = 0;
  localparam int BYP_MOD_BIT     = 1;
  localparam int OUTSEL_LSB      = 4;
  localparam int DRIVE_BIT       = 7;
  localparam int PLAY_L_STAT_BIT = 7;
  localparam int PLAY_R_STAT_BIT = 3;
  localparam int REC_L_STAT_BIT  = 6;
  localparam int REC_R_STAT_BIT  = 2;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ROOT_SEL = 8'h00;
  localparam logic [7:0] RST_DIV      = 8'h01;
  localparam logic [7:0] RST_OSR_HI   = 8'h00;
  localparam logic [7:0] RST_OSR_LO   = 8'h80;
  localparam logic [7:0] RST_REC_OSR  = 8'h80;
  localparam logic [7:0] RST_BYPASS   = 8'h03;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam int         NUM_ROOT_SRC = 11;
  localparam int         SYNC_W       = 12;
  localparam int         SHUTDOWN_MOD_TICKS = 16;

  // channel power tracking, gray along off -> on -> draining
  typedef enum logic [1:0] {
    PWR_OFF   = 2'b00,
    PWR_ON    = 2'b01,
    PWR_DRAIN = 2'b11
  } cdt_pwr_state_type;

endpackage

`default_nettype wire

// file: rtl/cdt_clock_tree.sv
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// divider stage: clocks are carried as a level plus a rise strobe
// ------------------------------------------------------------------
module cdt_div #(
  parameter int W = 7
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         en_in,
  input  wire logic [W-1:0] ratio_in,
  input  wire logic         lvl_in,
  input  wire logic         rise_in,
  output logic              lvl_out,
  output logic              rise_out
);
  logic [W-1:0] act_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W:0]   n;
  logic         nxt;

  // all-zero ratio field means the largest ratio
  assign n = (act_q == '0) ? {1'b1, {W{1'b0}}} : {1'b0, act_q};

  // count input rises; ratio swaps only at wrap or while disabled, so no runt pulses
  always_comb begin
    cnt_d = cnt_q;
    if (rise_in) begin
      if ({1'b0, cnt_q} == n - 1'b1) begin
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    if (n == {{W{1'b0}}, 1'b1}) begin
      nxt = lvl_in;
    end else begin
      nxt = ({1'b0, cnt_d} < (n >> 1));
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_q    <= '0;
      cnt_q    <= '0;
      lvl_out  <= 1'b0;
      rise_out <= 1'b0;
    end else if (!en_in) begin
      act_q    <= ratio_in;
      cnt_q    <= '0;
      lvl_out  <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      if (rise_in && cnt_d == '0) begin
        act_q <= ratio_in;
      end
      lvl_out  <= nxt;
      rise_out <= nxt & ~lvl_out;
    end
  end
endmodule

// Overview of operation
// - playback root chosen by upper selector nibble
// - record root chosen by lower nibble, independently
// - eleven root sources per selector
// - modulator is root over N times M; oversampled
// - N,M 1..128; oversample 1..1024 and 1..256
// - record core from playback or record N
// - record modulator from playback or record M
// - bypassed record rate uses playback root, N
// - playback shutdown sequence, two status bits
// - record shutdown sequence, two status bits
// - port one bit clock output selector
// - port two bit clock output selector
// - port three bit clock output selector
// - port one bit divider, enable, source mux
// - port two bit divider, enable, source mux
// - port three bit divider, enable, source mux
module cdt_clock_tree (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        master_clk_pin_a_in,
  input  wire logic        master_clk_pin_b_in,
  input  wire logic        port1_bitclk_pin_in,
  input  wire logic        port2_bitclk_pin_in,
  input  wire logic        port3_bitclk_pin_in,
  input  wire logic        general_io_a_in,
  input  wire logic        general_io_b_in,
  input  wire logic        general_in_a_in,
  input  wire logic        general_in_b_in,
  input  wire logic        synth_clk_in,
  input  wire logic        onchip_hf_reference_in,
  input  wire logic        onchip_hf_oscillator_in,
  output logic             play_core_clk_out,
  output logic             play_modulator_clk_out,
  output logic             play_sample_clk_out,
  output logic             rec_core_clk_out,
  output logic             rec_modulator_clk_out,
  output logic             rec_sample_clk_out,
  output logic [2:0]       port_bitclk_drive_out,
  output logic [2:0]       port_bitclk_oe_out
);
  import cdt_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  logic [SYNC_W-1:0] pin_rise;

  // order matches root selector codes; index 11 is port three
  assign pin_raw = {port3_bitclk_pin_in, general_in_b_in, general_io_b_in,
                    onchip_hf_oscillator_in, onchip_hf_reference_in,
                    general_in_a_in, port2_bitclk_pin_in, synth_clk_in,
                    general_io_a_in, port1_bitclk_pin_in,
                    master_clk_pin_b_in, master_clk_pin_a_in};
  assign pin_rise = sync2_q & ~sync3_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] root_sel_q, play_n_q, play_m_q, osr_hi_q, osr_lo_q;
  logic [7:0] rec_n_q, rec_m_q, rec_osr_q, bypass_q, chan_pwr_q;
  logic [7:0] bsrc_q [3];
  logic [7:0] bdiv_q [3];
  logic [7:0] bsel_q [3];
  logic [7:0] play_stat, rec_stat;
  logic [9:0] idx;
  logic       wr_en;
  logic [7:0] rd_d;
  logic       hit_d;

  assign idx   = paddr_in[11:2];
  assign wr_en = psel_in & penable_in & pwrite_in & pready_out;

  // decode, used for both read data and the error answer
  always_comb begin
    hit_d = 1'b1;
    rd_d  = 8'h00;
    case (idx)
      IDX_ROOT_SEL:    rd_d = root_sel_q;
      IDX_PLAY_N:      rd_d = play_n_q;
      IDX_PLAY_M:      rd_d = play_m_q;
      IDX_PLAY_OSR_HI: rd_d = {6'h00, osr_hi_q[1:0]};
      IDX_PLAY_OSR_LO: rd_d = osr_lo_q;
      IDX_REC_N:       rd_d = rec_n_q;
      IDX_REC_M:       rd_d = rec_m_q;
      IDX_REC_OSR:     rd_d = rec_osr_q;
      IDX_BYPASS:      rd_d = {6'h00, bypass_q[1:0]};
      IDX_CHAN_POWER:  rd_d = {4'h0, chan_pwr_q[3:0]};
      IDX_REC_STATUS:  rd_d = rec_stat;
      IDX_PLAY_STATUS: rd_d = play_stat;
      IDX_P1_SRC:      rd_d = {6'h00, bsrc_q[0][1:0]};
      IDX_P1_DIV:      rd_d = bdiv_q[0];
      IDX_P1_OUTSEL:   rd_d = bsel_q[0];
      IDX_P2_SRC:      rd_d = {6'h00, bsrc_q[1][1:0]};
      IDX_P2_DIV:      rd_d = bdiv_q[1];
      IDX_P2_OUTSEL:   rd_d = bsel_q[1];
      IDX_P3_SRC:      rd_d = {6'h00, bsrc_q[2][1:0]};
      IDX_P3_DIV:      rd_d = bdiv_q[2];
      IDX_P3_OUTSEL:   rd_d = bsel_q[2];
      default:         hit_d = 1'b0;
    endcase
  end

  // zero-wait slave: answer in the first access cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~hit_d;
      if (psel_in && !penable_in && !pwrite_in) begin
        prdata_out <= {24'h00_0000, rd_d};
      end
    end
  end

  // software writes; status registers ignore writes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      root_sel_q <= RST_ROOT_SEL;
      play_n_q   <= RST_DIV;
      play_m_q   <= RST_DIV;
      osr_hi_q   <= RST_OSR_HI;
      osr_lo_q   <= RST_OSR_LO;
      rec_n_q    <= RST_DIV;
      rec_m_q    <= RST_DIV;
      rec_osr_q  <= RST_REC_OSR;
      bypass_q   <= RST_BYPASS;
      chan_pwr_q <= RST_ZERO;
      for (int i = 0; i < 3; i++) begin
        bsrc_q[i] <= RST_ZERO;
        bdiv_q[i] <= RST_DIV;
        bsel_q[i] <= RST_ZERO;
      end
    end else if (wr_en) begin
      case (idx)
        IDX_ROOT_SEL:    root_sel_q <= pwdata_in[7:0];
        IDX_PLAY_N:      play_n_q   <= pwdata_in[7:0];
        IDX_PLAY_M:      play_m_q   <= pwdata_in[7:0];
        IDX_PLAY_OSR_HI: osr_hi_q   <= pwdata_in[7:0];
        IDX_PLAY_OSR_LO: osr_lo_q   <= pwdata_in[7:0];
        IDX_REC_N:       rec_n_q    <= pwdata_in[7:0];
        IDX_REC_M:       rec_m_q    <= pwdata_in[7:0];
        IDX_REC_OSR:     rec_osr_q  <= pwdata_in[7:0];
        IDX_BYPASS:      bypass_q   <= pwdata_in[7:0];
        IDX_CHAN_POWER:  chan_pwr_q <= pwdata_in[7:0];
        IDX_P1_SRC:      bsrc_q[0]  <= pwdata_in[7:0];
        IDX_P1_DIV:      bdiv_q[0]  <= pwdata_in[7:0];
        IDX_P1_OUTSEL:   bsel_q[0]  <= pwdata_in[7:0];
        IDX_P2_SRC:      bsrc_q[1]  <= pwdata_in[7:0];
        IDX_P2_DIV:      bdiv_q[1]  <= pwdata_in[7:0];
        IDX_P2_OUTSEL:   bsel_q[1]  <= pwdata_in[7:0];
        IDX_P3_SRC:      bsrc_q[2]  <= pwdata_in[7:0];
        IDX_P3_DIV:      bdiv_q[2]  <= pwdata_in[7:0];
        IDX_P3_OUTSEL:   bsel_q[2]  <= pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // root selection, switched only while both sources are low
  // ----------------------------------------------------------------
  logic [3:0] root_act_q [2];
  logic [1:0] root_lvl, root_rise;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      root_lvl[p]  = 1'b0;
      root_rise[p] = 1'b0;
      if (root_act_q[p] < 4'(NUM_ROOT_SRC)) begin
        root_lvl[p]  = sync2_q[root_act_q[p]];
        root_rise[p] = pin_rise[root_act_q[p]];
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      root_act_q[0] <= RST_ROOT_SEL[PLAY_ROOT_LSB +: 4];
      root_act_q[1] <= RST_ROOT_SEL[REC_ROOT_LSB +: 4];
    end else begin
      if (!root_lvl[0] && (root_sel_q[PLAY_ROOT_LSB +: 4] >= 4'(NUM_ROOT_SRC)
          || !sync2_q[root_sel_q[PLAY_ROOT_LSB +: 4]])) begin
        root_act_q[0] <= root_sel_q[PLAY_ROOT_LSB +: 4];
      end
      if (!root_lvl[1] && (root_sel_q[REC_ROOT_LSB +: 4] >= 4'(NUM_ROOT_SRC)
          || !sync2_q[root_sel_q[REC_ROOT_LSB +: 4]])) begin
        root_act_q[1] <= root_sel_q[REC_ROOT_LSB +: 4];
      end
    end
  end

  // ----------------------------------------------------------------
  // converter divider chains
  // ----------------------------------------------------------------
  logic pn_l, pn_r, pm_l, pm_r, po_l, po_r;
  logic rn_l, rn_r, rm_l, rm_r, ro_l, ro_r;
  logic rc_l, rc_r, rmod_l, rmod_r;

  cdt_div #(.W(7)) u_play_n (.clk_in(clk_in), .rst_in(rst_in),
    .en_in(play_n_q[POWER_BIT]), .ratio_in(play_n_q[6:0]),
    .lvl_in(root_lvl[0]), .rise_in(root_rise[0]),
    .lvl_out(pn_l), .rise_out(pn_r));
  cdt_div #(.W(7)) u_play_m (.clk_in(clk_in), .rst_in(rst_in),
    .en_in(play_m_q[POWER_BIT]), .ratio_in(play_m_q[6:0]),
    .lvl_in(pn_l), .rise_in(pn_r), .lvl_out(pm_l), .rise_out(pm_r));
  cdt_div #(.W(10)) u_play_osr (.clk_in(clk_in), .rst_in(rst_in),
    .en_in(play_m_q[POWER_BIT]), .ratio_in({osr_hi_q[1:0], osr_lo_q}),
    .lvl_in(pm_l), .rise_in(pm_r),
    .lvl_out(po_l), .rise_out(po_r));
  cdt_div #(.W(7)) u_rec_n (.clk_in(clk_in), .rst_in(rst_in),
    .en_in(rec_n_q[POWER_BIT]), .ratio_in(rec_n_q[6:0]),
    .lvl_in(root_lvl[1]), .rise_in(root_rise[1]),
    .lvl_out(rn_l), .rise_out(rn_r));

  // record core may come from the playback N output
  assign rc_l = bypass_q[BYP_CORE_BIT] ? pn_l : rn_l;
  assign rc_r = bypass_q[BYP_CORE_BIT] ? pn_r : rn_r;

  cdt_div #(.W(7)) u_rec_m (.clk_in(clk_in), .rst_in(rst_in),
    .en_in(rec_m_q[POWER_BIT]), .ratio_in(rec_m_q[6:0]),
    .lvl_in(rc_l), .rise_in(rc_r), .lvl_out(rm_l), .rise_out(rm_r));

  // record modulator may come from the playback M output
  assign rmod_l = bypass_q[BYP_MOD_BIT] ? pm_l : rm_l;
  assign rmod_r = bypass_q[BYP_MOD_BIT] ? pm_r : rm_r;

  // oversampler runs whenever its selected M source is powered
  cdt_div #(.W(8)) u_rec_osr (.clk_in(clk_in), .rst_in(rst_in),
    .en_in(bypass_q[BYP_MOD_BIT] ? play_m_q[POWER_BIT]
                                 : rec_m_q[POWER_BIT]),
    .ratio_in(rec_osr_q), .lvl_in(rmod_l), .rise_in(rmod_r),
    .lvl_out(ro_l), .rise_out(ro_r));

  // ----------------------------------------------------------------
  // channel power-down sequencing, paced by modulator clock
  // ----------------------------------------------------------------
  cdt_pwr_state_type pwr_q [4];
  logic [7:0]        drain_q [4];
  logic [3:0]        mod_tick;

  // a stopped modulator stalls the drain, hence the divider ordering
  assign mod_tick = {rmod_r, rmod_r, pm_r, pm_r};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int c = 0; c < 4; c++) begin
        pwr_q[c]   <= PWR_OFF;
        drain_q[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        case (pwr_q[c])
          PWR_OFF: begin
            drain_q[c] <= 8'h00;
            if (chan_pwr_q[c]) begin
              pwr_q[c] <= PWR_ON;
            end
          end
          PWR_ON: begin
            drain_q[c] <= 8'h00;
            if (!chan_pwr_q[c]) begin
              pwr_q[c] <= PWR_DRAIN;
            end
          end
          PWR_DRAIN: begin
            if (chan_pwr_q[c]) begin
              pwr_q[c] <= PWR_ON;
            end else if (mod_tick[c]) begin
              if (drain_q[c] == 8'(SHUTDOWN_MOD_TICKS - 1)) begin
                pwr_q[c] <= PWR_OFF;
              end else begin
                drain_q[c] <= drain_q[c] + 8'h01;
              end
            end
          end
          default: pwr_q[c] <= PWR_OFF;
        endcase
      end
    end
  end

  // status bit reads one until the channel is fully down
  always_comb begin
    play_stat = 8'h00;
    rec_stat  = 8'h00;
    play_stat[PLAY_L_STAT_BIT] = (pwr_q[0] != PWR_OFF);
    play_stat[PLAY_R_STAT_BIT] = (pwr_q[1] != PWR_OFF);
    rec_stat[REC_L_STAT_BIT]   = (pwr_q[2] != PWR_OFF);
    rec_stat[REC_R_STAT_BIT]   = (pwr_q[3] != PWR_OFF);
  end

  // ----------------------------------------------------------------
  // serial port bit clocks
  // ----------------------------------------------------------------
  logic [3:0] core_lvl, core_rise;
  logic [2:0] bd_l, bd_r, bin_l, bin_r;
  logic [2:0] port_pin;

  assign core_lvl  = {rmod_l, rc_l, pm_l, pn_l};
  assign core_rise = {rmod_r, rc_r, pm_r, pn_r};
  assign port_pin  = {sync2_q[11], sync2_q[5], sync2_q[2]};

  for (genvar g = 0; g < 3; g++) begin : g_port
    assign bin_l[g] = core_lvl[bsrc_q[g][1:0]];
    assign bin_r[g] = core_rise[bsrc_q[g][1:0]];
    cdt_div #(.W(7)) u_bdiv (.clk_in(clk_in), .rst_in(rst_in),
      .en_in(bdiv_q[g][POWER_BIT]), .ratio_in(bdiv_q[g][6:0]),
      .lvl_in(bin_l[g]), .rise_in(bin_r[g]),
      .lvl_out(bd_l[g]), .rise_out(bd_r[g]));
  end

  // codes 3 and 4 pick the other two ports' incoming bit clocks
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_bitclk_drive_out <= 3'h0;
      port_bitclk_oe_out    <= 3'h0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        port_bitclk_oe_out[p] <= bsel_q[p][DRIVE_BIT];
        case (bsel_q[p][OUTSEL_LSB +: 3])
          3'h0: port_bitclk_drive_out[p] <= bd_l[0];
          3'h1: port_bitclk_drive_out[p] <= bd_l[1];
          3'h2: port_bitclk_drive_out[p] <= bd_l[2];
          3'h3: port_bitclk_drive_out[p] <= port_pin[(p == 0) ? 1 : 0];
          3'h4: port_bitclk_drive_out[p] <= port_pin[(p == 2) ? 1 : 2];
          default: port_bitclk_drive_out[p] <= 1'b0;
        endcase
      end
    end
  end

  // registered copies of the tree clocks for the converters
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      play_core_clk_out      <= 1'b0;
      play_modulator_clk_out <= 1'b0;
      play_sample_clk_out    <= 1'b0;
      rec_core_clk_out       <= 1'b0;
      rec_modulator_clk_out  <= 1'b0;
      rec_sample_clk_out     <= 1'b0;
    end else begin
      play_core_clk_out      <= pn_l;
      play_modulator_clk_out <= pm_l;
      play_sample_clk_out    <= po_l;
      rec_core_clk_out       <= rc_l;
      rec_modulator_clk_out  <= rmod_l;
      rec_sample_clk_out     <= ro_l;
    end
  end

endmodule

`default_nettype wire

// file: testbench/cdt_clock_tree_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------
// bus answer and pin enable checks
// ---------------------------------------
module cdt_chk (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [2:0]  port_bitclk_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // answer always one cycle after setup
  a_ready_after_setup: assert property (
    psel_in && !penable_in |=> pready_out) else $error("ready late");
  a_ready_single: assert property (
    pready_out |=> !pready_out) else $error("ready held");
  a_ready_in_access: assert property (
    pready_out |-> psel_in && penable_in) else $error("stray ready");
  a_ready_had_setup: assert property (
    pready_out |-> $past(psel_in && !penable_in)) else $error("no setup");
  a_err_with_ready: assert property (
    pslverr_out |-> pready_out) else $error("error without ready");
  a_rdata_narrow: assert property (
    prdata_out[31:8] == 24'h000000) else $error("upper bits set");
  // read data only moves on a read setup
  a_rdata_hold: assert property (
    !(psel_in && !penable_in && !pwrite_in) |=> $stable(prdata_out))
    else $error("read data moved");
  // pin enable follows a committed write only
  a_oe_by_write: assert property (
    !$stable(port_bitclk_oe_out) |-> $past(pwrite_in && penable_in)
    || $past(pwrite_in && penable_in, 2)) else $error("oe moved");
endmodule
bind cdt_clock_tree cdt_chk cdt_chk_i (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .port_bitclk_oe_out(port_bitclk_oe_out));
`default_nettype wire

// file: testbench/cdt_clock_tree_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin \
  bad_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module cdt_clock_tree_test;
  import cdt_pkg::*;
  logic        clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0;
  logic        pwrite_in = 0, pready_out, pslverr_out, pin_a = 0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rq = 32'h40, rm = 32'h40;
  logic [10:0] pins = 11'h000;
  wire  [5:0]  clks;
  logic [2:0]  drv, oe;
  logic [6:0]  prv = 7'h00;
  logic [32:0] ex, expq[$];
  wire  [6:0]  sig = {clks[5], clks[2], clks[0], clks[4], clks[3],
                      clks[1], drv[0]};
  int          bad_count = 0, checked = 0, ph = 0, cnt[7];
  bit          cnt_on = 0;
  always #2 clk_in = ~clk_in;
  cdt_clock_tree cdt_clock_tree_i (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .master_clk_pin_a_in(pin_a), .master_clk_pin_b_in(pins[0]),
    .port1_bitclk_pin_in(pins[1]), .port2_bitclk_pin_in(pins[2]),
    .port3_bitclk_pin_in(pins[3]), .general_io_a_in(pins[4]),
    .general_io_b_in(pins[5]), .general_in_a_in(pins[6]),
    .general_in_b_in(pins[7]), .synth_clk_in(pins[8]),
    .onchip_hf_reference_in(pins[9]), .onchip_hf_oscillator_in(pins[10]),
    .play_core_clk_out(clks[5]), .play_modulator_clk_out(clks[4]),
    .play_sample_clk_out(clks[3]), .rec_core_clk_out(clks[2]),
    .rec_modulator_clk_out(clks[1]), .rec_sample_clk_out(clks[0]),
    .port_bitclk_drive_out(drv), .port_bitclk_oe_out(oe));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic near(input int c, input int e);
    return c >= e - 1 && c <= e + 1;
  endfunction
  // pin a period 16; other pins slow random so the syncs see them
  always @(posedge clk_in) begin
    ph <= ph + 1;
    if (ph % 8 == 7) pin_a <= ~pin_a;
    if (ph % 16 == 0) begin
      rq <= xs(rq);
      pins <= rq[10:0];
    end
  end
  // read answers against the oldest note; edge counting
  always @(posedge clk_in) begin
    if (pready_out === 1'b1 && !pwrite_in) begin
      ex = expq.pop_front();
      `CHK("rdata", ex, {pslverr_out, prdata_out})
    end
    for (int i = 0; i < 7; i++) if (cnt_on && sig[i] && !prv[i]) cnt[i]++;
    prv <= sig;
  end
  // request held until ready; release left to the next call
  task automatic bus(input logic w, input logic [9:0] ix,
                     input logic [7:0] d, input logic e = 1'b0);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= {ix, 2'b00};
    pwdata_in <= {24'h0, d};
    if (!w) expq.push_back({e, 24'h0, e ? 8'h00 : d});
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
  endtask
  task automatic idle(input int n);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic end_sim;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    end_sim;
  end
  initial begin
    logic [9:0]  rx[5];
    logic [17:0] cf[10];
    rx = '{IDX_ROOT_SEL, IDX_REC_OSR, IDX_P2_DIV, IDX_P3_DIV, IDX_REC_N};
    // oversample ratios before M power: they load while still off
    cf = '{{IDX_ROOT_SEL, 8'h00}, {IDX_PLAY_N, 8'h81},
      {IDX_PLAY_OSR_HI, 8'h00}, {IDX_PLAY_OSR_LO, 8'h02},
      {IDX_REC_OSR, 8'h02}, {IDX_PLAY_M, 8'h84}, {IDX_BYPASS, 8'h03},
      {IDX_P1_SRC, 8'h01}, {IDX_P1_DIV, 8'h81}, {IDX_P1_OUTSEL, 8'h80}};
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    bus(0, IDX_ROOT_SEL, RST_ROOT_SEL);
    bus(0, IDX_PLAY_N, RST_DIV);
    bus(0, IDX_PLAY_OSR_LO, RST_OSR_LO);
    bus(0, IDX_BYPASS, RST_BYPASS);
    bus(0, IDX_P1_DIV, RST_DIV);
    bus(0, 10'h3ff, 8'h00, 1'b1);
    bus(1, IDX_REC_STATUS, 8'hff);
    bus(0, IDX_REC_STATUS, RST_ZERO);
    foreach (rx[i]) begin
      rm = xs(rm);
      bus(1, rx[i], rm[7:0]);
      bus(0, rx[i], rm[7:0]);
    end
    foreach (cf[i]) bus(1, cf[i][17:8], cf[i][7:0]);
    idle(200);
    cnt = '{0, 0, 0, 0, 0, 0, 0};
    cnt_on <= 1'b1;
    repeat (640) @(posedge clk_in);
    cnt_on <= 1'b0;
    `CHK("mod", 1'b1, near(cnt[3], 10))
    `CHK("rate", 1'b1, near(cnt[2], 5))
    `CHK("recmod", 1'b1, near(cnt[1], 10))
    `CHK("bitclk", 1'b1, near(cnt[0], 10))
    `CHK("core", 1'b1, near(cnt[6], 40))
    `CHK("reccore", 1'b1, near(cnt[5], 40))
    `CHK("recrate", 1'b1, near(cnt[4], 5))
    `CHK("oe", 3'b001, oe)
    // drain runs on the modulator; stopping it freezes status
    bus(1, IDX_CHAN_POWER, 8'h01);
    idle(2);
    bus(0, IDX_PLAY_STATUS, 8'h80);
    bus(1, IDX_CHAN_POWER, 8'h00);
    idle(2);
    bus(0, IDX_PLAY_STATUS, 8'h80);
    idle(1300);
    bus(0, IDX_PLAY_STATUS, 8'h00);
    bus(1, IDX_REC_N, 8'h81);
    bus(1, IDX_REC_M, 8'h81);
    bus(1, IDX_CHAN_POWER, 8'h0e);
    idle(2);
    bus(0, IDX_PLAY_STATUS, 8'h08);
    bus(0, IDX_REC_STATUS, 8'h44);
    bus(1, IDX_PLAY_M, 8'h04);
    bus(1, IDX_CHAN_POWER, 8'h00);
    idle(1300);
    `CHK("modoff", 1'b0, clks[4])
    bus(0, IDX_PLAY_STATUS, 8'h08);
    bus(0, IDX_REC_STATUS, 8'h44);
    bus(1, IDX_PLAY_M, 8'h84);
    idle(1300);
    bus(0, IDX_PLAY_STATUS, 8'h00);
    bus(0, IDX_REC_STATUS, 8'h00);
    // children before parents, each only once its status is down
    bus(1, IDX_REC_M, 8'h01);
    bus(1, IDX_REC_N, 8'h01);
    bus(1, IDX_PLAY_M, 8'h04);
    bus(1, IDX_PLAY_N, 8'h01);
    idle(4);
    `CHK("coreoff", 1'b0, clks[5])
    end_sim;
  end
endmodule
`default_nettype wire
